// *** rtl/pflsb_bank.sv ***
// Command bank of a digitally controlled converter: limits, reactions,
// status flags, power-good and turn-on sequencing.
// Assumes the transaction layer and telemetry run on clk_sys.
// Function
// - Command 0x35 holds lockout turn-on level, default 35 V, range 33-36 V.
// - Command 0x36 holds lockout turn-off level, default 33 V, range 31-34 V.
// - Command 0x40 holds output overvoltage fault limit, default 15 V, 11-16 V.
// - Command 0x42 holds overvoltage warning, default 14 V, not above fault.
// - Command 0x41 reads fixed overvoltage reaction 0xB8.
// - Command 0x47 reads fixed overcurrent reaction 0xF8.
// - Command 0x56 reads fixed input overvoltage reaction 0xF8.
// - Command 0x50 reads fixed over-temperature reaction 0xB8.
// - Command 0x46 holds overcurrent fault, default 38 A, above warning.
// - Command 0x4A holds overcurrent warning, default 32 A, below fault.
// - Command 0x4F holds over-temperature fault, default 125 C, above warning.
// - Command 0x51 holds temperature warning, default 100 C, below fault.
// - Command 0x55 holds input overvoltage fault, default 100 V, 48-110 V.
// - Power-good bit rises when output reaches the 0x5E level.
// - Power-good bit falls when output reaches the 0x5F level.
// - Wait the 0x60 delay after a start before the output rises.
// - Ramp the output over the 0x61 rise time.
// - Command 0x79 returns the summary status word.
// - Command 0x7A returns output voltage fault and warning flags.
// - Command 0x7B returns output current fault and warning flags.
// - Non-output quantities use 5-bit exponent over 11-bit mantissa.
// - Output-voltage quantities use unsigned 16-bit mantissa, exponent -12.
// - Retry field all ones means shut down and keep restarting.
`timescale 1ns/1ns
module pflsb_bank #(
    parameter int UNIT_CYCLES = pflsb_pkg::UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic clear_faults,
    input wire logic on_request,
    input wire logic [15:0] meas_vin,
    input wire logic [15:0] meas_vout,
    input wire logic [15:0] meas_iout,
    input wire logic [15:0] meas_temp,
    output logic rd_valid_q,
    output logic [15:0] rd_data_q,
    output logic wr_reject_q,
    output logic power_good_q,
    output logic conv_enable_q,
    output logic ramp_active_q
);
    localparam int PRE_W = $clog2(UNIT_CYCLES + 1);

    typedef enum logic [2:0] {
        S_OFF = 3'h0,
        S_DELAY = 3'h1,
        S_RISE = 3'h2,
        S_ON = 3'h3,
        S_LATCH = 3'h4
    } pflsb_seq_e;

    logic [15:0] thr_q [pflsb_pkg::NTHR];
    logic hit;
    logic [3:0] idx;
    logic in_rng;
    logic x_ok;
    logic wr_req;
    logic wr_ok;
    logic flag_w;
    logic [15:0] rd_d;
    logic [7:0] vout_flags_q;
    logic [7:0] iout_flags_q;
    logic ot_fault_q;
    logic ot_warn_q;
    logic vin_ov_q;
    logic cml_q;
    logic vin_ok_q;
    logic [15:0] status_word;
    pflsb_seq_e st_q;
    pflsb_seq_e st_d;
    logic [PRE_W-1:0] pre_q;
    logic [10:0] tcnt_q;
    logic [10:0] tcnt_d;
    logic tick;
    logic load;
    logic start;

    // ==========================================================
    // Live limit comparisons; whole words compare because exponents are fixed
    logic ovf_now;
    logic ovw_now;
    logic ocf_now;
    logic ocw_now;
    logic otf_now;
    logic otw_now;
    logic vinov_now;
    logic fault_now;
    logic restart_ok;

    assign ovf_now = meas_vout >= thr_q[pflsb_pkg::IX_OVF];
    assign ovw_now = meas_vout >= thr_q[pflsb_pkg::IX_OVW];
    assign ocf_now = meas_iout >= thr_q[pflsb_pkg::IX_OCF];
    assign ocw_now = meas_iout >= thr_q[pflsb_pkg::IX_OCW];
    assign otf_now = meas_temp >= thr_q[pflsb_pkg::IX_OTF];
    assign otw_now = meas_temp >= thr_q[pflsb_pkg::IX_OTW];
    assign vinov_now = meas_vin >= thr_q[pflsb_pkg::IX_VINOV];
    assign fault_now = ovf_now | ocf_now | otf_now | vinov_now;
    // Any tripped source whose retry field is not all ones latches off
    assign restart_ok = ~((ovf_now & ~&pflsb_pkg::R_OVR[pflsb_pkg::RETRY_HI:pflsb_pkg::RETRY_LO])
        | (ocf_now & ~&pflsb_pkg::R_OCR[pflsb_pkg::RETRY_HI:pflsb_pkg::RETRY_LO])
        | (otf_now & ~&pflsb_pkg::R_OTR[pflsb_pkg::RETRY_HI:pflsb_pkg::RETRY_LO])
        | (vinov_now & ~&pflsb_pkg::R_VIR[pflsb_pkg::RETRY_HI:pflsb_pkg::RETRY_LO]));

    // ==========================================================
    // Write decode and checks
    always_comb begin
        hit = 1'b0;
        idx = 4'h0;
        for (int i = 0; i < pflsb_pkg::NTHR; i++) begin
            if (cmd_code == pflsb_pkg::CODE[i]) begin
                hit = 1'b1;
                idx = 4'(i);
            end
        end
    end

    assign in_rng = (cmd_wdata >= pflsb_pkg::MINV[idx])
        && (cmd_wdata <= pflsb_pkg::MAXV[idx]);

    // Paired limits except the lockout levels are checked against the partner's current value
    always_comb begin
        unique case (idx)
            pflsb_pkg::IX_OVF: x_ok = cmd_wdata >= thr_q[pflsb_pkg::IX_OVW];
            pflsb_pkg::IX_OVW: x_ok = cmd_wdata <= thr_q[pflsb_pkg::IX_OVF];
            pflsb_pkg::IX_OCF: x_ok = cmd_wdata > thr_q[pflsb_pkg::IX_OCW];
            pflsb_pkg::IX_OCW: x_ok = cmd_wdata < thr_q[pflsb_pkg::IX_OCF];
            pflsb_pkg::IX_OTF: x_ok = cmd_wdata > thr_q[pflsb_pkg::IX_OTW];
            pflsb_pkg::IX_OTW: x_ok = cmd_wdata < thr_q[pflsb_pkg::IX_OTF];
            pflsb_pkg::IX_PGON: x_ok = cmd_wdata > thr_q[pflsb_pkg::IX_PGOFF];
            pflsb_pkg::IX_PGOFF: x_ok = cmd_wdata < thr_q[pflsb_pkg::IX_PGON];
            default: x_ok = 1'b1;
        endcase
    end

    assign wr_req = cmd_valid & cmd_write;
    assign wr_ok = wr_req & hit & in_rng & x_ok;
    assign flag_w = wr_req & ((cmd_code == pflsb_pkg::C_SVOUT) | (cmd_code == pflsb_pkg::C_SIOUT));

    // ==========================================================
    // Threshold storage
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < pflsb_pkg::NTHR; i++) begin
            if (!rst_n) begin
                thr_q[i] <= pflsb_pkg::DFLT[i];
            end else if (wr_ok && idx == 4'(i)) begin
                thr_q[i] <= cmd_wdata;
            end
        end
    end

    // ==========================================================
    // Sticky status flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vout_flags_q <= 8'h00;
        end else begin
            vout_flags_q[pflsb_pkg::SV_OVF] <= ovf_now | (vout_flags_q[pflsb_pkg::SV_OVF]
                & ~clear_faults & ~(wr_req && cmd_code == pflsb_pkg::C_SVOUT
                && cmd_wdata[pflsb_pkg::SV_OVF]));
            vout_flags_q[pflsb_pkg::SV_OVW] <= ovw_now | (vout_flags_q[pflsb_pkg::SV_OVW]
                & ~clear_faults & ~(wr_req && cmd_code == pflsb_pkg::C_SVOUT
                && cmd_wdata[pflsb_pkg::SV_OVW]));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            iout_flags_q <= 8'h00;
        end else begin
            iout_flags_q[pflsb_pkg::SI_OCF] <= ocf_now | (iout_flags_q[pflsb_pkg::SI_OCF]
                & ~clear_faults & ~(wr_req && cmd_code == pflsb_pkg::C_SIOUT
                && cmd_wdata[pflsb_pkg::SI_OCF]));
            iout_flags_q[pflsb_pkg::SI_OCW] <= ocw_now | (iout_flags_q[pflsb_pkg::SI_OCW]
                & ~clear_faults & ~(wr_req && cmd_code == pflsb_pkg::C_SIOUT
                && cmd_wdata[pflsb_pkg::SI_OCW]));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ot_fault_q <= 1'b0;
            ot_warn_q <= 1'b0;
            vin_ov_q <= 1'b0;
        end else begin
            ot_fault_q <= otf_now | (ot_fault_q & ~clear_faults);
            ot_warn_q <= otw_now | (ot_warn_q & ~clear_faults);
            vin_ov_q <= vinov_now | (vin_ov_q & ~clear_faults);
        end
    end

    // Rejected writes raise the communication flag; unknown reads answer zero only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cml_q <= 1'b0;
        end else begin
            cml_q <= (wr_req & ~wr_ok & ~flag_w) | (cml_q & ~clear_faults);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_reject_q <= 1'b0;
        end else begin
            wr_reject_q <= wr_req & ~wr_ok & ~flag_w;
        end
    end

    // ==========================================================
    // Summary word
    always_comb begin
        status_word = 16'h0000;
        status_word[pflsb_pkg::SW_OFF] = ~conv_enable_q;
        status_word[pflsb_pkg::SW_OVF] = vout_flags_q[pflsb_pkg::SV_OVF];
        status_word[pflsb_pkg::SW_OCF] = iout_flags_q[pflsb_pkg::SI_OCF];
        status_word[pflsb_pkg::SW_VINUV] = ~vin_ok_q;
        status_word[pflsb_pkg::SW_TEMP] = ot_fault_q | ot_warn_q;
        status_word[pflsb_pkg::SW_CML] = cml_q;
        status_word[pflsb_pkg::SW_VOUT] = |vout_flags_q;
        status_word[pflsb_pkg::SW_IOUT] = |iout_flags_q;
        status_word[pflsb_pkg::SW_INPUT] = vin_ov_q;
        status_word[pflsb_pkg::SW_PGOOD] = power_good_q;
    end

    // ==========================================================
    // Read path, answered one cycle after the request
    always_comb begin
        rd_d = 16'h0000;
        if (hit) begin
            rd_d = thr_q[idx];
        end else begin
            unique case (cmd_code)
                pflsb_pkg::C_OVR: rd_d = {8'h00, pflsb_pkg::R_OVR};
                pflsb_pkg::C_OCR: rd_d = {8'h00, pflsb_pkg::R_OCR};
                pflsb_pkg::C_VIR: rd_d = {8'h00, pflsb_pkg::R_VIR};
                pflsb_pkg::C_OTR: rd_d = {8'h00, pflsb_pkg::R_OTR};
                pflsb_pkg::C_SWORD: rd_d = status_word;
                pflsb_pkg::C_SVOUT: rd_d = {8'h00, vout_flags_q};
                pflsb_pkg::C_SIOUT: rd_d = {8'h00, iout_flags_q};
                default: rd_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            rd_valid_q <= cmd_valid & ~cmd_write;
            if (cmd_valid && !cmd_write) begin
                rd_data_q <= rd_d;
            end
        end
    end

    // ==========================================================
    // Input lockout with hysteresis between the two levels
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            vin_ok_q <= 1'b0;
        end else if (meas_vin >= thr_q[pflsb_pkg::IX_VINON]) begin
            vin_ok_q <= 1'b1;
        end else if (meas_vin < thr_q[pflsb_pkg::IX_VINOFF]) begin
            vin_ok_q <= 1'b0;
        end
    end

    // ==========================================================
    // Turn-on sequencer; times count 0.5 ms steps of the mantissa
    assign start = on_request & vin_ok_q;
    assign tick = pre_q == PRE_W'(UNIT_CYCLES - 1);

    always_comb begin
        st_d = st_q;
        load = 1'b0;
        tcnt_d = 11'h000;
        unique case (st_q)
            S_OFF: begin
                if (start) begin
                    st_d = S_DELAY;
                    load = 1'b1;
                    tcnt_d = thr_q[pflsb_pkg::IX_TOND][10:0];
                end
            end
            S_DELAY: begin
                if (!start) begin
                    st_d = S_OFF;
                end else if (tick && tcnt_q <= 11'h001) begin
                    st_d = S_RISE;
                    load = 1'b1;
                    tcnt_d = thr_q[pflsb_pkg::IX_TONR][10:0];
                end
            end
            S_RISE, S_ON: begin
                if (!start) begin
                    st_d = S_OFF;
                end else if (fault_now) begin
                    // Hiccup: the turn-on delay doubles as the restart interval
                    st_d = restart_ok ? S_DELAY : S_LATCH;
                    load = 1'b1;
                    tcnt_d = thr_q[pflsb_pkg::IX_TOND][10:0];
                end else if (st_q == S_RISE && tick && tcnt_q <= 11'h001) begin
                    st_d = S_ON;
                end
            end
            S_LATCH: begin
                if (!on_request) begin
                    st_d = S_OFF;
                end
            end
            default: st_d = S_OFF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= S_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || load) begin
            pre_q <= '0;
        end else if (tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tcnt_q <= 11'h000;
        end else if (load) begin
            tcnt_q <= tcnt_d;
        end else if (tick && tcnt_q != 11'h000) begin
            tcnt_q <= tcnt_q - 11'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            conv_enable_q <= 1'b0;
            ramp_active_q <= 1'b0;
        end else begin
            conv_enable_q <= (st_d == S_RISE) || (st_d == S_ON);
            ramp_active_q <= st_d == S_RISE;
        end
    end

    // ==========================================================
    // Power good with on/off hysteresis
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            power_good_q <= 1'b0;
        end else if (!conv_enable_q || meas_vout <= thr_q[pflsb_pkg::IX_PGOFF]) begin
            power_good_q <= 1'b0;
        end else if (meas_vout >= thr_q[pflsb_pkg::IX_PGON]) begin
            power_good_q <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence rd_of(logic [7:0] c);
        cmd_valid && !cmd_write && cmd_code == c;
    endsequence

    sequence bad_write;
        wr_req && hit && !in_rng;
    endsequence

    read_answer_a: assert property (rd_of(pflsb_pkg::C_SWORD) |=> rd_valid_q && rd_data_q == $past(status_word))
        else $error("status word read not answered next cycle");
    ov_react_a: assert property (rd_of(pflsb_pkg::C_OVR) |=> rd_data_q == 16'h00B8)
        else $error("overvoltage reaction byte wrong");
    oc_react_a: assert property (rd_of(pflsb_pkg::C_OCR) |=> rd_data_q == 16'h00F8)
        else $error("overcurrent reaction byte wrong");
    range_reject_a: assert property (bad_write |=> wr_reject_q && thr_q[$past(idx)] == $past(thr_q[idx]))
        else $error("out of range write altered a threshold");
    warn_order_a: assert property (thr_q[pflsb_pkg::IX_OCW] < thr_q[pflsb_pkg::IX_OCF])
        else $error("overcurrent warning not below fault");
    pgood_set_a: assert property (conv_enable_q && !power_good_q && meas_vout >= thr_q[pflsb_pkg::IX_PGON]
        && meas_vout > thr_q[pflsb_pkg::IX_PGOFF] |=> power_good_q)
        else $error("power good not raised");
    pgood_clr_a: assert property (power_good_q && meas_vout <= thr_q[pflsb_pkg::IX_PGOFF] |=> !power_good_q)
        else $error("power good not dropped");
    ovf_flag_a: assert property (ovf_now |=> vout_flags_q[pflsb_pkg::SV_OVF] [*1] ##1 1'b1)
        else $error("overvoltage fault flag not set");
    ocf_flag_a: assert property (ocf_now |=> iout_flags_q[pflsb_pkg::SI_OCF])
        else $error("overcurrent fault flag not set");
    hiccup_a: assert property ((st_q == S_ON || st_q == S_RISE) && start && fault_now
        |=> st_q == S_DELAY && !conv_enable_q)
        else $error("fault did not start a hiccup restart");
    delay_first_a: assert property ($rose(st_q == S_RISE) |-> $past(st_q) == S_DELAY)
        else $error("rise entered without turn-on delay");
    uvlo_on_a: assert property (!vin_ok_q && meas_vin >= thr_q[pflsb_pkg::IX_VINON] |=> vin_ok_q)
        else $error("lockout not released at turn-on level");
endmodule : pflsb_bank

// *** rtl/pflsb_pkg.sv ***
// Constants for the fault limit and status command bank.
// Assumes linear-format words with the fixed exponents listed below.
package pflsb_pkg;
    // ==========================================================
    // Threshold table, index order
    localparam int NTHR = 13;
    localparam logic [3:0] IX_VINON = 4'h0;
    localparam logic [3:0] IX_VINOFF = 4'h1;
    localparam logic [3:0] IX_OVF = 4'h2;
    localparam logic [3:0] IX_OVW = 4'h3;
    localparam logic [3:0] IX_OCF = 4'h4;
    localparam logic [3:0] IX_OCW = 4'h5;
    localparam logic [3:0] IX_OTF = 4'h6;
    localparam logic [3:0] IX_OTW = 4'h7;
    localparam logic [3:0] IX_VINOV = 4'h8;
    localparam logic [3:0] IX_PGON = 4'h9;
    localparam logic [3:0] IX_PGOFF = 4'hA;
    localparam logic [3:0] IX_TOND = 4'hB;
    localparam logic [3:0] IX_TONR = 4'hC;
    localparam logic [7:0] CODE [NTHR] = '{8'h35, 8'h36, 8'h40, 8'h42, 8'h46, 8'h4A,
        8'h4F, 8'h51, 8'h55, 8'h5E, 8'h5F, 8'h60, 8'h61};
    // Exponents -3 (E9xx), -12 (plain), -4 (E2xx), -2 (Fxxx), -1 (F8xx)
    localparam logic [15:0] DFLT [NTHR] = '{16'hE918, 16'hE908, 16'hF000, 16'hE000,
        16'hE260, 16'hE200, 16'hF1F4, 16'hF190, 16'hEB20, 16'hB000, 16'h9000,
        16'hF828, 16'hF83C};
    localparam logic [15:0] MINV [NTHR] = '{16'hE908, 16'hE8F8, 16'hB000, 16'hB000,
        16'hE140, 16'hE140, 16'hF064, 16'hF064, 16'hE980, 16'h8000, 16'h8000,
        16'hF80A, 16'hF81E};
    localparam logic [15:0] MAXV [NTHR] = '{16'hE920, 16'hE910, 16'hFFFF, 16'hFFFF,
        16'hE280, 16'hE280, 16'hF230, 16'hF230, 16'hEB70, 16'hD333, 16'hD333,
        16'hFBE8, 16'hFBE8};
    // ==========================================================
    // Other command codes and fixed reaction bytes
    localparam logic [7:0] C_OVR = 8'h41;
    localparam logic [7:0] C_OCR = 8'h47;
    localparam logic [7:0] C_OTR = 8'h50;
    localparam logic [7:0] C_VIR = 8'h56;
    localparam logic [7:0] C_SWORD = 8'h79;
    localparam logic [7:0] C_SVOUT = 8'h7A;
    localparam logic [7:0] C_SIOUT = 8'h7B;
    localparam logic [7:0] R_OVR = 8'hB8;
    localparam logic [7:0] R_OCR = 8'hF8;
    localparam logic [7:0] R_OTR = 8'hB8;
    localparam logic [7:0] R_VIR = 8'hF8;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    // ==========================================================
    // Status bit positions
    localparam int SV_OVF = 7;
    localparam int SV_OVW = 6;
    localparam int SI_OCF = 7;
    localparam int SI_OCW = 5;
    localparam int SW_OFF = 6;
    localparam int SW_OVF = 5;
    localparam int SW_OCF = 4;
    localparam int SW_VINUV = 3;
    localparam int SW_TEMP = 2;
    localparam int SW_CML = 1;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_PGOOD = 11;
    // ==========================================================
    // Timing: one time-mantissa step is 0.5 ms
    localparam int CLK_NS = 10;
    localparam int TIME_UNIT_NS = 500000;
    localparam int UNIT_CYC = TIME_UNIT_NS / CLK_NS;
endpackage : pflsb_pkg

// *** verification/pflsb_bank_tb_top.sv ***
// Self-checking bench for the command bank, host model on the command port.
// Assumes UNIT_CYCLES is shortened to 4 so sequencing stays short.
`timescale 1ns/1ns
module pflsb_bank_tb_top;
    logic clk_sys, rst_n, clear_faults, on_request, cmd_valid, cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, meas_vin, meas_vout, meas_iout, meas_temp, rd_data_q;
    logic rd_valid_q, wr_reject_q, power_good_q, conv_enable_q, ramp_active_q;
    int fails = 0;
    int n_compared = 0;
    int n;
    pflsb_host i_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .wr_reject_q(wr_reject_q));
    pflsb_bank #(.UNIT_CYCLES(4)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
        .on_request(on_request), .meas_vin(meas_vin), .meas_vout(meas_vout), .meas_iout(meas_iout),
        .meas_temp(meas_temp), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .wr_reject_q(wr_reject_q),
        .power_good_q(power_good_q), .conv_enable_q(conv_enable_q), .ramp_active_q(ramp_active_q));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] q;
        logic a;
        i_host.xfer(1'b0, c, 16'h0000, q, a);
        chk({15'h0, a}, 16'h0001);
        chk(q, exp);
    endtask : rdc
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic rej);
        logic [15:0] q;
        logic a;
        i_host.xfer(1'b1, c, d, q, a);
        chk({15'h0, a}, {15'h0, rej});
    endtask : wr
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc
    // Bounded wait on the enable level, n is the cycles it took
    task automatic wait_en(input logic lvl);
        for (n = 1; n < 300; n++) begin
            cyc(1);
            if (conv_enable_q === lvl) break;
        end
    endtask : wait_en
    task automatic summarize();
        $display("compared=%0d fails=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Scenarios
    task automatic t_defaults();
        for (int i = 0; i < pflsb_pkg::NTHR; i++) begin
            rdc(pflsb_pkg::CODE[i], pflsb_pkg::DFLT[i]);
        end
        rdc(8'h41, 16'h00B8);
        rdc(8'h47, 16'h00F8);
        rdc(8'h56, 16'h00F8);
        rdc(8'h50, 16'h00B8);
        rdc(8'h79, 16'h0048);
    endtask : t_defaults
    task automatic t_limits();
        wr(8'h41, 16'h0000, 1'b1);
        wr(8'h35, 16'hE930, 1'b1);
        rdc(8'h35, 16'hE918);
        rdc(8'h79, 16'h004A);
        @(posedge clk_sys);
        clear_faults <= 1'b1;
        @(posedge clk_sys);
        clear_faults <= 1'b0;
        rdc(8'h79, 16'h0048);
        // Lockout pair is written so that turn-on stays above turn-off
        wr(8'h36, 16'hE8F8, 1'b0);
        wr(8'h35, 16'hE910, 1'b0);
        rdc(8'h35, 16'hE910);
        wr(8'h4A, 16'hE260, 1'b1);
        wr(8'h46, 16'hE1F0, 1'b1);
        wr(8'h42, 16'hF800, 1'b1);
        wr(8'h42, 16'hF000, 1'b0);
        wr(8'h51, 16'hF1F4, 1'b1);
        wr(8'h4F, 16'hF190, 1'b1);
        wr(8'h5E, 16'h9000, 1'b1);
        wr(8'h55, 16'hEB80, 1'b1);
        wr(8'h99, 16'h0000, 1'b1);
        rdc(8'h99, 16'h0000);
        wr(8'h60, 16'hF80A, 1'b0);
        wr(8'h61, 16'hF81E, 1'b0);
        @(posedge clk_sys);
        clear_faults <= 1'b1;
        @(posedge clk_sys);
        clear_faults <= 1'b0;
    endtask : t_limits
    task automatic t_flags();
        @(posedge clk_sys);
        meas_vout <= 16'hF000;
        meas_iout <= 16'hE260;
        meas_temp <= 16'hF190;
        meas_vin <= 16'hEB20;
        cyc(3);
        rdc(8'h7A, 16'h00C0);
        rdc(8'h7B, 16'h00A0);
        rdc(8'h79, 16'hE074);
        @(posedge clk_sys);
        meas_vout <= 16'h0000;
        meas_iout <= 16'h0000;
        meas_temp <= 16'h0000;
        meas_vin <= 16'h0000;
        wr(8'h7A, 16'h00C0, 1'b0);
        wr(8'h7B, 16'h00A0, 1'b0);
        rdc(8'h7A, 16'h0000);
        rdc(8'h7B, 16'h0000);
        @(posedge clk_sys);
        clear_faults <= 1'b1;
        @(posedge clk_sys);
        clear_faults <= 1'b0;
        rdc(8'h79, 16'h0048);
    endtask : t_flags
    task automatic t_seq();
        @(posedge clk_sys);
        meas_vin <= 16'hE918;
        cyc(3);
        rdc(8'h79, 16'h0040);
        @(posedge clk_sys);
        on_request <= 1'b1;
        wait_en(1'b1);
        chk({15'h0, n >= 38 && n <= 43}, 16'h0001);
        for (n = 0; n < 300 && ramp_active_q === 1'b1; n++) cyc(1);
        chk({15'h0, n >= 117 && n <= 122}, 16'h0001);
        @(posedge clk_sys);
        meas_vout <= 16'hC000;
        cyc(3);
        chk({15'h0, power_good_q}, 16'h0001);
        rdc(8'h79, 16'h0800);
        @(posedge clk_sys);
        meas_vout <= 16'hA000;
        cyc(3);
        chk({15'h0, power_good_q}, 16'h0001);
        @(posedge clk_sys);
        meas_vout <= 16'h9000;
        cyc(3);
        chk({15'h0, power_good_q}, 16'h0000);
        @(posedge clk_sys);
        meas_vout <= 16'hF000;
        cyc(3);
        chk({15'h0, conv_enable_q}, 16'h0000);
        @(posedge clk_sys);
        meas_vout <= 16'hC000;
        wait_en(1'b1);
        chk({15'h0, n >= 35 && n <= 39}, 16'h0001);
        @(posedge clk_sys);
        on_request <= 1'b0;
        cyc(3);
        chk({15'h0, conv_enable_q}, 16'h0000);
    endtask : t_seq
    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        clear_faults = 1'b0;
        on_request = 1'b0;
        meas_vin = 16'h0000;
        meas_vout = 16'h0000;
        meas_iout = 16'h0000;
        meas_temp = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_defaults();
        t_limits();
        t_flags();
        t_seq();
        summarize();
    end
    // Tests need about 360 cycles, so this is ample
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end
endmodule : pflsb_bank_tb_top

// *** verification/pflsb_host.sv ***
// Host model on the command port of the bank: one command per call.
// Assumes the bank takes a strobe at one edge and answers at the next.
`timescale 1ns/1ns
module pflsb_host (
    input wire logic clk_sys,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic rd_valid_q,
    input wire logic [15:0] rd_data_q,
    input wire logic wr_reject_q
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Idle lines are inverted so that a stale code or word is never trusted
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
        output logic [15:0] q, output logic ack);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
        cmd_wdata <= ~d;
        #1;
        q = rd_data_q;
        ack = w ? wr_reject_q : rd_valid_q;
    endtask : xfer
endmodule : pflsb_host
